/* File: rtl/afp_pkg.sv */
/*
  Constants and carrier types for the amplifier fault supervisor.
  Assumes a 40 MHz ref_clk and digital comparator inputs from the analog
  front end (over-current, over-temperature, supply window, PWM sign).
*/
// Overview of operation
// - Output short: flag low, bridge high-Z, fault latched.
// - Die above 150 C: shutdown, bridge off, flag low, latched.
// - Duty above 60% at one polarity beyond 420 ms raises DC fault.
// - DC fault: flag low, bridge high-Z, latched until cleared.
// - Latches clear only by shutdown_n low; restart from high-Z.
// - Power-up interval of 10 ms before normal operation.
// - shutdown_n low mutes outputs and enters low-current state.
package afp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned POWERUP_MS    = 10;
  localparam int unsigned DC_HOLD_MS    = 420;
  localparam int unsigned POWERUP_CYC   = CLK_HZ / 1000 * POWERUP_MS;
  localparam int unsigned DC_HOLD_CYC   = CLK_HZ / 1000 * DC_HOLD_MS;
  localparam int unsigned DC_WIN_CYC    = 100;
  localparam int unsigned DC_DUTY_PCT   = 60;
  localparam int unsigned DC_HIGH_LIM   = DC_WIN_CYC * DC_DUTY_PCT / 100;
  localparam int unsigned CNT_W         = 32;
  localparam int unsigned WIN_W         = 8;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    AFP_POWERUP = 2'b00,
    AFP_SHUTDN  = 2'b01,
    AFP_RUN     = 2'b10,
    AFP_FAULT   = 2'b11
  } afp_state_e;

  // Latched fault causes
  typedef struct packed {
    logic dc_fault;
    logic over_temp;
    logic over_curr;
  } afp_fault_s;

  localparam afp_fault_s FAULT_NONE = '{default: 1'b0};

endpackage

/* File: rtl/afp_dc_detect.sv */
/*
  Per-channel DC detector: measures the fraction of ref_clk cycles a
  PWM differential sign is high or low over fixed windows, and flags a
  channel whose windows keep one polarity above the duty limit too long.
  Assumes synchronised sign inputs and an active-low clear.
*/
`timescale 1ns/100ps
module afp_dc_detect #(
  parameter int unsigned HOLD_CYC = afp_pkg::DC_HOLD_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // Control
  input  wire logic enable,
  // Sampled sign: 1 means positive differential drive
  input  wire logic sign_pos,
  // Result
  output logic      dc_hit
);

  logic [afp_pkg::WIN_W-1:0] win_reg;
  logic [afp_pkg::WIN_W-1:0] pos_reg;
  logic [afp_pkg::CNT_W-1:0] hold_reg;
  logic [1:0]                pol_reg;
  logic                      hit_reg;

  // ----------------------------------------------------------------
  // Window evaluation
  // ----------------------------------------------------------------
  wire win_end  = (win_reg == afp_pkg::WIN_W'(afp_pkg::DC_WIN_CYC - 1));
  wire [afp_pkg::WIN_W-1:0] pos_tot = pos_reg + afp_pkg::WIN_W'(sign_pos);
  wire [afp_pkg::WIN_W-1:0] neg_tot =
    afp_pkg::WIN_W'(afp_pkg::DC_WIN_CYC) - pos_tot;
  wire hi_pos = pos_tot > afp_pkg::WIN_W'(afp_pkg::DC_HIGH_LIM);
  wire hi_neg = neg_tot > afp_pkg::WIN_W'(afp_pkg::DC_HIGH_LIM);
  wire [1:0] pol_now = {hi_neg, hi_pos};
  // Same polarity window after window keeps the timer running
  wire keep = (pol_now != 2'b00) && (pol_now == pol_reg || pol_reg == 2'b00);
  wire [afp_pkg::CNT_W-1:0] win_cyc = afp_pkg::CNT_W'(afp_pkg::DC_WIN_CYC);
  wire timeout = hold_reg >= afp_pkg::CNT_W'(HOLD_CYC);

  always_ff @(posedge ref_clk) begin
    if (!nrst || !enable) begin
      win_reg  <= '0;
      pos_reg  <= '0;
      hold_reg <= '0;
      pol_reg  <= 2'b00;
      hit_reg  <= 1'b0;
    end else if (win_end) begin
      win_reg  <= '0;
      pos_reg  <= '0;
      pol_reg  <= keep ? pol_now : 2'b00;
      hold_reg <= keep ? hold_reg + win_cyc : '0;
      hit_reg  <= keep && timeout;
    end else begin
      win_reg  <= win_reg + 1'b1;
      pos_reg  <= pos_tot;
    end
  end

  assign dc_hit = hit_reg;

endmodule

/* File: rtl/afp_fault_ctrl.sv */
/*
  Fault supervisor for a stereo switching amplifier: power-up hold-off,
  shutdown handling, latched over-current, over-temperature and DC
  faults, and self-clearing supply window faults.
  Assumes analog comparators deliver asynchronous digital levels; the
  system processor drives shutdown_n and watches fault_flag_n.
*/
`timescale 1ns/100ps
module afp_fault_ctrl #(
  parameter int unsigned POWERUP_CYC = afp_pkg::POWERUP_CYC,
  parameter int unsigned DC_HOLD_CYC = afp_pkg::DC_HOLD_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // System control
  input  wire logic shutdown_n,
  // Analog comparator levels
  input  wire logic over_curr,
  input  wire logic over_temp,
  input  wire logic supply_low,
  input  wire logic supply_high,
  input  wire logic sign_pos_l,
  input  wire logic sign_pos_r,
  // Status and bridge control
  output logic      fault_flag_n,
  output logic      bridge_en,
  output logic      low_power,
  output logic      mute
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every pin is asynchronous to ref_clk; two stages each
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end else begin
      sync1_reg <= {shutdown_n, over_curr, over_temp, supply_low,
                    supply_high, sign_pos_l, sign_pos_r};
      sync2_reg <= sync1_reg;
    end
  end

  wire sd_n_s  = sync2_reg[6];
  wire oc_s    = sync2_reg[5];
  wire ot_s    = sync2_reg[4];
  wire uv_s    = sync2_reg[3];
  wire ov_s    = sync2_reg[2];
  wire sgn_l_s = sync2_reg[1];
  wire sgn_r_s = sync2_reg[0];

  // ----------------------------------------------------------------
  // State and latches
  // ----------------------------------------------------------------
  afp_pkg::afp_state_e       state_reg;
  afp_pkg::afp_state_e       state_next;
  afp_pkg::afp_fault_s       fault_reg;
  afp_pkg::afp_fault_s       fault_next;
  logic [afp_pkg::CNT_W-1:0] pu_reg;

  wire running   = (state_reg == afp_pkg::AFP_RUN);
  wire supply_ok = !uv_s && !ov_s;
  wire dc_l;
  wire dc_r;

  // One test for an empty latch set keeps flag and restart in step
  function automatic logic no_fault(afp_pkg::afp_fault_s f);
    return f == afp_pkg::FAULT_NONE;
  endfunction

  // ----------------------------------------------------------------
  // DC detectors
  // ----------------------------------------------------------------
  afp_dc_detect #(.HOLD_CYC(DC_HOLD_CYC)) u_dc_l (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .enable   (running && supply_ok),
    .sign_pos (sgn_l_s),
    .dc_hit   (dc_l)
  );

  afp_dc_detect #(.HOLD_CYC(DC_HOLD_CYC)) u_dc_r (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .enable   (running && supply_ok),
    .sign_pos (sgn_r_s),
    .dc_hit   (dc_r)
  );

  // New fault causes: over-current and DC while running, over-temperature in any state
  wire new_oc = running && oc_s;
  wire new_ot = ot_s;
  wire new_dc = running && (dc_l || dc_r);
  wire any_new = new_oc || new_ot || new_dc;

  // Set wins over clear: a fault seen during shutdown stays latched
  always_comb begin
    fault_next = fault_reg;
    if (!sd_n_s) begin
      fault_next = afp_pkg::FAULT_NONE;
    end
    if (new_oc) begin
      fault_next.over_curr = 1'b1;
    end
    if (new_ot) begin
      fault_next.over_temp = 1'b1;
    end
    if (new_dc) begin
      fault_next.dc_fault = 1'b1;
    end
  end

  wire pu_done = (pu_reg >= afp_pkg::CNT_W'(POWERUP_CYC - 1));

  always_comb begin
    case (state_reg)
      afp_pkg::AFP_POWERUP: begin
        state_next = pu_done ? afp_pkg::AFP_SHUTDN
                             : afp_pkg::AFP_POWERUP;
      end
      afp_pkg::AFP_SHUTDN: begin
        // Restart from high-Z only once latches are clear
        state_next = (sd_n_s && no_fault(fault_reg))
                     ? afp_pkg::AFP_RUN : afp_pkg::AFP_SHUTDN;
      end
      afp_pkg::AFP_RUN: begin
        if (any_new) begin
          state_next = afp_pkg::AFP_FAULT;
        end else if (!sd_n_s) begin
          state_next = afp_pkg::AFP_SHUTDN;
        end else begin
          state_next = afp_pkg::AFP_RUN;
        end
      end
      afp_pkg::AFP_FAULT: begin
        state_next = sd_n_s ? afp_pkg::AFP_FAULT
                            : afp_pkg::AFP_SHUTDN;
      end
      default: begin
        state_next = afp_pkg::AFP_POWERUP;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= afp_pkg::AFP_POWERUP;
      fault_reg <= afp_pkg::FAULT_NONE;
      pu_reg    <= '0;
    end else begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      pu_reg    <= pu_done ? pu_reg : pu_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic flag_n_reg;
  logic bridge_reg;
  logic lowp_reg;
  logic mute_reg;
  // Supply faults gate the bridge and the DC detectors but never touch the flag
  wire bridge_next = (state_next == afp_pkg::AFP_RUN) && supply_ok
                     && !any_new;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flag_n_reg <= 1'b1;
      bridge_reg <= 1'b0;
      lowp_reg   <= 1'b1;
      mute_reg   <= 1'b1;
    end else begin
      flag_n_reg <= no_fault(fault_next);
      bridge_reg <= bridge_next;
      lowp_reg   <= (state_next != afp_pkg::AFP_RUN);
      mute_reg   <= (state_next != afp_pkg::AFP_RUN);
    end
  end

  assign fault_flag_n = flag_n_reg;
  assign bridge_en    = bridge_reg;
  assign low_power    = lowp_reg;
  assign mute         = mute_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence oc_seen_s;
    running && oc_s;
  endsequence

  oc_latch_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    oc_seen_s |=> !fault_flag_n && !bridge_en)
    else $error("over-current did not latch fault");

  ot_latch_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    ot_s |=> !fault_flag_n && !bridge_en)
    else $error("over-temperature did not shut down");

  dc_latch_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    running && (dc_l || dc_r) |=> fault_reg.dc_fault && !bridge_en)
    else $error("dc fault not latched");

  fault_hold_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !fault_flag_n && sd_n_s |=> !fault_flag_n)
    else $error("fault cleared without shutdown");

  // A new cause in the clearing cycle wins, so it is left out here
  fault_clear_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !sd_n_s && !any_new |=> no_fault(fault_reg) && !bridge_en)
    else $error("shutdown did not clear latches");

  pu_hold_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !pu_done |-> !bridge_en)
    else $error("bridge enabled during power-up");

  sd_mute_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !sd_n_s |=> mute && low_power && !bridge_en)
    else $error("shutdown did not mute");

  supply_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    (uv_s || ov_s) && no_fault(fault_reg) && !any_new
    |=> !bridge_en && fault_flag_n)
    else $error("supply fault handled wrongly");

endmodule

/* File: test/afp_sys_model.sv */
/*
  System processor model at the far side of the fault supervisor.
  Assumes the bench requests shutdown levels; the model may feed the
  fault flag back into shutdown_n for automatic recovery.
*/
`timescale 1ns/100ps
module afp_sys_model (
  // Bench requests
  input  wire logic sd_req_n,
  input  wire logic auto_en,
  // Device side
  input  wire logic fault_flag_n,
  output logic      shutdown_n,
  output logic      mute_ctl_n
);
  // --------------------------------------------------------------
  // Recovery wiring
  // --------------------------------------------------------------
  // Flag into shutdown clears latches with no software involved
  assign shutdown_n = sd_req_n & (fault_flag_n | ~auto_en);
  // Flag drives active-low mute directly so a persistent short restarts in high-Z
  assign mute_ctl_n = fault_flag_n;
endmodule

/* File: test/tb.sv */
/*
  Self-checking bench for the amplifier fault supervisor.
  Assumes shortened power-up and DC hold counts; signs toggle each cycle
  unless a DC scenario pins one channel.
*/
`timescale 1ns/100ps
module tb;
  localparam int PU = 50;
  localparam int DH = 1000;
  logic       ref_clk, nrst, sd_req_n, auto_en, shutdown_n, tog;
  logic       over_curr, over_temp, supply_low, supply_high;
  logic [1:0] dc_on;
  logic       fault_flag_n, bridge_en, low_power, mute, mute_ctl_n;
  int         n_fail, tests_run, cyc;

  afp_fault_ctrl #(.POWERUP_CYC(PU), .DC_HOLD_CYC(DH)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .shutdown_n(shutdown_n),
    .over_curr(over_curr), .over_temp(over_temp),
    .supply_low(supply_low), .supply_high(supply_high),
    .sign_pos_l(dc_on[0] | tog), .sign_pos_r(~dc_on[1] & tog),
    .fault_flag_n(fault_flag_n), .bridge_en(bridge_en),
    .low_power(low_power), .mute(mute));
  afp_sys_model u_sys (.sd_req_n(sd_req_n), .auto_en(auto_en),
    .fault_flag_n(fault_flag_n), .shutdown_n(shutdown_n),
    .mute_ctl_n(mute_ctl_n));

  // --------------------------------------------------------------
  // Clock, sign toggling, hang guard
  // --------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    tog <= #1 ~tog;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(string nm, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  function automatic logic sig(int k);
    return (k == 0) ? fault_flag_n : bridge_en;
  endfunction
  // Bounded poll; the compare that follows judges the outcome
  task automatic await(int k, logic v, int lim);
    for (int i = 0; i < lim && sig(k) !== v; i++) step(1);
  endtask
  task automatic clear_latch();
    sd_req_n = 1'b0;
    step(6);
    chk("flag after clear", 1'b1, fault_flag_n);
    chk("bridge held off", 1'b0, bridge_en);
    chk("mute in shutdown", 1'b1, mute);
    chk("low_power in shutdown", 1'b1, low_power);
    sd_req_n = 1'b1;
    await(1, 1'b1, 10);
    chk("bridge restart", 1'b1, bridge_en);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_powerup();
    step(30);
    sd_req_n = 1'b1;
    step(10);
    chk("bridge in power-up", 1'b0, bridge_en);
    chk("flag in power-up", 1'b1, fault_flag_n);
    chk("mute in power-up", 1'b1, mute);
    await(1, 1'b1, 30);
    chk("bridge after power-up", 1'b1, bridge_en);
    chk("mute running", 1'b0, mute);
    chk("low_power running", 1'b0, low_power);
    $display("t_powerup done");
  endtask
  task automatic t_latch(int k);
    if (k == 0) over_curr = 1'b1;
    else over_temp = 1'b1;
    await(0, 1'b0, 8);
    chk("flag on fault", 1'b0, fault_flag_n);
    chk("bridge on fault", 1'b0, bridge_en);
    chk("mute ctl on fault", 1'b0, mute_ctl_n);
    over_curr = 1'b0;
    over_temp = 1'b0;
    step(20);
    chk("flag latched", 1'b0, fault_flag_n);
    clear_latch();
    $display("t_latch %0d done", k);
  endtask
  task automatic t_dc(int ch);
    dc_on[ch] = 1'b1;
    step(DH - 100);
    chk("no early dc fault", 1'b1, fault_flag_n);
    await(0, 1'b0, 400);
    chk("dc fault flag", 1'b0, fault_flag_n);
    chk("dc fault bridge", 1'b0, bridge_en);
    dc_on = 2'h0;
    step(30);
    chk("dc fault latched", 1'b0, fault_flag_n);
    clear_latch();
    $display("t_dc %0d done", ch);
  endtask
  task automatic t_supply(int k);
    if (k == 0) supply_low = 1'b1;
    else supply_high = 1'b1;
    await(1, 1'b0, 8);
    chk("supply bridge off", 1'b0, bridge_en);
    chk("supply no flag", 1'b1, fault_flag_n);
    supply_low = 1'b0;
    supply_high = 1'b0;
    await(1, 1'b1, 8);
    chk("supply resume", 1'b1, bridge_en);
    $display("t_supply %0d done", k);
  endtask
  task automatic t_auto();
    auto_en = 1'b1;
    over_curr = 1'b1;
    step(2);
    over_curr = 1'b0;
    await(0, 1'b0, 8);
    chk("auto flag low", 1'b0, fault_flag_n);
    chk("auto mute ctl", 1'b0, mute_ctl_n);
    await(0, 1'b1, 12);
    chk("auto flag cleared", 1'b1, fault_flag_n);
    await(1, 1'b1, 12);
    chk("auto bridge back", 1'b1, bridge_en);
    auto_en = 1'b0;
    $display("t_auto done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    sd_req_n = 1'b0;
    {auto_en, over_curr, over_temp, supply_low, supply_high, tog} = 6'h0;
    dc_on = 2'h0;
    {n_fail, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
    step(5);
    nrst = 1'b1;
    t_powerup();
    t_latch(0);
    t_latch(1);
    t_dc(0);
    t_dc(1);
    t_supply(0);
    t_supply(1);
    t_auto();
    tally_and_finish();
  end
endmodule
